/* hdl/sfp_params.svh */
// constants for the sample fifo element packer
// Operation
// - a sample holds at most four slots, set by the two slot registers
// - every element is 24 bits wide, narrow readings zero-filled at the top
// - fifo data reads return only bytes of active elements, or 00 when none is active
// - two 8-bit slot registers hold the four codes, both reset to zero
// - code 0001 selects infrared optical reading, 0010 the red one
// - code 0101 selects infrared pilot reading, 0110 the red pilot one
// - code 1001 selects the 18-bit cardio reading, 0000 means unused
// - optical readings are left-justified with msb at bit 18, low bits zero
// - cardio readings are right-justified, bits 23 to 18 are zero
// - enabled slots land at indices from zero up, in slot order, with no gaps
// - each element is delivered as three bytes of the data register
// - element bytes go out most significant first
`ifndef SFP_PARAMS_SVH
`define SFP_PARAMS_SVH

// register addresses
`define SFP_ADDR_FIFO_DATA 8'h07
`define SFP_ADDR_SLOT_LOW 8'h09
`define SFP_ADDR_SLOT_HIGH 8'h0a
`define SFP_SLOT_RESET 8'h00

// bus slave address, arbitrary value
`define SFP_SLAVE_ID 7'h2a

// slot codes
`define SFP_CODE_NONE 4'h0
`define SFP_CODE_IR 4'h1
`define SFP_CODE_RED 4'h2
`define SFP_CODE_IR_PILOT 4'h5
`define SFP_CODE_RED_PILOT 4'h6
`define SFP_CODE_CARDIO 4'h9

// element layout
`define SFP_ELEM_W 24
`define SFP_OPT_W 19
`define SFP_CARDIO_W 18
`define SFP_SLOTS 4
`define SFP_BYTES_PER_ELEM 2'h3
`define SFP_LAST_BYTE 2'h2
`define SFP_RES_MAX 2'h3

`endif

/* hdl/sfp_pkg.sv */
// types for the sample fifo element packer
package sfp_pkg;

    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_ADDR = 7'h02,
        ST_REG = 7'h04,
        ST_WDATA = 7'h08,
        ST_ACK = 7'h10,
        ST_READ = 7'h20,
        ST_RACK = 7'h40
    } sfp_bus_state_type;

endpackage

/* hdl/sfp_i2c_slave.sv */
// serial bus slave giving byte access to the packer registers
`timescale 1ns/100ps
`include "sfp_params.svh"
module sfp_i2c_slave (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // bus pins
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_oe_o,
    // register access
    output logic [7:0] addr_o,
    output logic [7:0] wdata_o,
    output logic wr_stb_o,
    output logic rd_stb_o,
    input wire logic [7:0] rdata_i
);
    logic [1:0] scl_sync_r;
    logic [1:0] sda_sync_r;
    logic scl_d_r;
    logic sda_d_r;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    sfp_pkg::sfp_bus_state_type state_r;
    logic [3:0] cnt_r;
    logic [7:0] shift_r;
    logic [7:0] tx_r;
    logic rw_r;
    logic reg_seen_r;
    logic nack_r;

    // pin synchronisers
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            scl_sync_r <= 2'h3;
            sda_sync_r <= 2'h3;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end
        else
        begin
            scl_sync_r <= {scl_sync_r[0], scl_i};
            sda_sync_r <= {sda_sync_r[0], sda_i};
            scl_d_r <= scl_sync_r[1];
            sda_d_r <= sda_sync_r[1];
        end
    end

    assign scl_rise = scl_sync_r[1] & ~scl_d_r;
    assign scl_fall = ~scl_sync_r[1] & scl_d_r;
    assign start_det = scl_sync_r[1] & scl_d_r & sda_d_r & ~sda_sync_r[1];
    assign stop_det = scl_sync_r[1] & scl_d_r & ~sda_d_r & sda_sync_r[1];
    assign wdata_o = shift_r;

    // protocol engine
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_r <= sfp_pkg::ST_IDLE;
            cnt_r <= 4'h0;
            shift_r <= 8'h00;
            tx_r <= 8'h00;
            rw_r <= 1'b0;
            reg_seen_r <= 1'b0;
            nack_r <= 1'b0;
            addr_o <= 8'h00;
            sda_oe_o <= 1'b0;
            wr_stb_o <= 1'b0;
            rd_stb_o <= 1'b0;
        end
        else
        begin
            wr_stb_o <= 1'b0;
            rd_stb_o <= 1'b0;
            if (start_det)
            begin
                state_r <= sfp_pkg::ST_ADDR;
                cnt_r <= 4'h0;
                reg_seen_r <= 1'b0;
                sda_oe_o <= 1'b0;
            end
            else if (stop_det)
            begin
                state_r <= sfp_pkg::ST_IDLE;
                sda_oe_o <= 1'b0;
            end
            else
            begin
                case (state_r)
                    sfp_pkg::ST_IDLE:
                    begin
                        cnt_r <= 4'h0;
                    end
                    sfp_pkg::ST_ADDR, sfp_pkg::ST_REG, sfp_pkg::ST_WDATA:
                    begin
                        if (scl_rise)
                        begin
                            shift_r <= {shift_r[6:0], sda_sync_r[1]};
                            cnt_r <= cnt_r + 4'h1;
                        end
                        else if (scl_fall && cnt_r == 4'h8)
                        begin
                            cnt_r <= 4'h0;
                            state_r <= sfp_pkg::ST_ACK;
                            sda_oe_o <= 1'b1;
                            if (state_r == sfp_pkg::ST_ADDR)
                            begin
                                rw_r <= shift_r[0];
                                if (shift_r[7:1] != `SFP_SLAVE_ID)
                                begin
                                    state_r <= sfp_pkg::ST_IDLE;
                                    sda_oe_o <= 1'b0;
                                end
                            end
                            else if (state_r == sfp_pkg::ST_REG)
                            begin
                                addr_o <= shift_r;
                                reg_seen_r <= 1'b1;
                            end
                            else
                            begin
                                wr_stb_o <= 1'b1;
                            end
                        end
                    end
                    sfp_pkg::ST_ACK:
                    begin
                        if (scl_fall)
                        begin
                            sda_oe_o <= 1'b0;
                            if (rw_r)
                            begin
                                state_r <= sfp_pkg::ST_READ;
                                tx_r <= {rdata_i[6:0], 1'b0};
                                sda_oe_o <= ~rdata_i[7];
                                rd_stb_o <= 1'b1;
                                if (addr_o != `SFP_ADDR_FIFO_DATA)
                                begin
                                    addr_o <= addr_o + 8'h01;
                                end
                            end
                            else if (!reg_seen_r)
                            begin
                                state_r <= sfp_pkg::ST_REG;
                            end
                            else
                            begin
                                state_r <= sfp_pkg::ST_WDATA;
                            end
                        end
                        else if (wr_stb_o)
                        begin
                            // step the address only once a data byte has landed
                            addr_o <= addr_o + 8'h01;
                        end
                    end
                    sfp_pkg::ST_READ:
                    begin
                        if (scl_rise)
                        begin
                            cnt_r <= cnt_r + 4'h1;
                        end
                        else if (scl_fall)
                        begin
                            if (cnt_r == 4'h8)
                            begin
                                state_r <= sfp_pkg::ST_RACK;
                                sda_oe_o <= 1'b0;
                                cnt_r <= 4'h0;
                            end
                            else
                            begin
                                sda_oe_o <= ~tx_r[7];
                                tx_r <= {tx_r[6:0], 1'b0};
                            end
                        end
                    end
                    sfp_pkg::ST_RACK:
                    begin
                        if (scl_rise)
                        begin
                            nack_r <= sda_sync_r[1];
                        end
                        else if (scl_fall)
                        begin
                            if (nack_r)
                            begin
                                state_r <= sfp_pkg::ST_IDLE;
                            end
                            else
                            begin
                                state_r <= sfp_pkg::ST_READ;
                                tx_r <= {rdata_i[6:0], 1'b0};
                                sda_oe_o <= ~rdata_i[7];
                                rd_stb_o <= 1'b1;
                                if (addr_o != `SFP_ADDR_FIFO_DATA)
                                begin
                                    addr_o <= addr_o + 8'h01;
                                end
                            end
                        end
                    end
                    default:
                    begin
                        state_r <= sfp_pkg::ST_IDLE;
                        sda_oe_o <= 1'b0;
                    end
                endcase
            end
        end
    end
endmodule

/* hdl/sfp_packer.sv */
// sample fifo element packer with its slot registers and serial access
`timescale 1ns/100ps
`include "sfp_params.svh"
module sfp_packer (
    // clock and reset
    input wire logic CORE_CLK_I,
    input wire logic RST_I,
    // serial bus pins
    input wire logic SCL_I,
    input wire logic SDA_I,
    output logic SDA_O,
    output logic SDA_OE_O,
    // readings from the front ends
    input wire logic [18:0] IR_READING_I,
    input wire logic [18:0] RED_READING_I,
    input wire logic [18:0] IR_PILOT_READING_I,
    input wire logic [18:0] RED_PILOT_READING_I,
    input wire logic [17:0] CARDIO_READING_I,
    input wire logic [1:0] OPT_RES_I,
    // sample handling
    input wire logic SAMPLE_STROBE_I,
    output logic SAMPLE_POP_O,
    output logic [2:0] ELEMENT_COUNT_O,
    output logic [7:0] SLOT_CONFIG_LOW_O,
    output logic [7:0] SLOT_CONFIG_HIGH_O
);
    logic [7:0] slot_config_low_pair_r;
    logic [7:0] slot_config_high_pair_r;
    logic [3:0] slot_code [`SFP_SLOTS];
    logic [23:0] packed_elem [`SFP_SLOTS];
    logic [2:0] packed_cnt;
    logic [23:0] sample_r [`SFP_SLOTS];
    logic [2:0] count_r;
    logic [1:0] elem_sel_r;
    logic [1:0] byte_sel_r;
    logic [7:0] fifo_byte;
    logic [7:0] rdata;
    logic [7:0] bus_addr;
    logic [7:0] bus_wdata;
    logic bus_wr;
    logic bus_rd;
    logic sda_oe;

    // optical reading aligned so its msb sits at bit 18
    function automatic logic [18:0] opt_justify(input logic [18:0] raw, input logic [1:0] res);
        logic [1:0] sh;
        sh = `SFP_RES_MAX - res;
        opt_justify = raw << sh;
    endfunction

    // element content for one slot code
    function automatic logic [23:0] slot_element(
        input logic [3:0] code,
        input logic [18:0] ir,
        input logic [18:0] red,
        input logic [18:0] ir_pilot,
        input logic [18:0] red_pilot,
        input logic [17:0] cardio
    );
        case (code)
            `SFP_CODE_IR: slot_element = {5'h00, ir};
            `SFP_CODE_RED: slot_element = {5'h00, red};
            `SFP_CODE_IR_PILOT: slot_element = {5'h00, ir_pilot};
            `SFP_CODE_RED_PILOT: slot_element = {5'h00, red_pilot};
            `SFP_CODE_CARDIO: slot_element = {6'h00, cardio};
            default: slot_element = 24'h000000;
        endcase
    endfunction

    // serial bus slave
    sfp_i2c_slave u_bus (
        .clk(CORE_CLK_I),
        .rst(RST_I),
        .scl_i(SCL_I),
        .sda_i(SDA_I),
        .sda_oe_o(sda_oe),
        .addr_o(bus_addr),
        .wdata_o(bus_wdata),
        .wr_stb_o(bus_wr),
        .rd_stb_o(bus_rd),
        .rdata_i(rdata)
    );

    assign SDA_O = 1'b0;
    assign SDA_OE_O = sda_oe;
    assign SLOT_CONFIG_LOW_O = slot_config_low_pair_r;
    assign SLOT_CONFIG_HIGH_O = slot_config_high_pair_r;
    assign ELEMENT_COUNT_O = count_r;

    // slot configuration registers
    always_ff @(posedge CORE_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            slot_config_low_pair_r <= `SFP_SLOT_RESET;
            slot_config_high_pair_r <= `SFP_SLOT_RESET;
        end
        else if (bus_wr)
        begin
            if (bus_addr == `SFP_ADDR_SLOT_LOW)
            begin
                slot_config_low_pair_r <= bus_wdata;
            end
            if (bus_addr == `SFP_ADDR_SLOT_HIGH)
            begin
                slot_config_high_pair_r <= bus_wdata;
            end
        end
    end

    // slot codes by slot number
    assign slot_code[0] = slot_config_low_pair_r[3:0];
    assign slot_code[1] = slot_config_low_pair_r[7:4];
    assign slot_code[2] = slot_config_high_pair_r[3:0];
    assign slot_code[3] = slot_config_high_pair_r[7:4];

    // enabled slots packed in slot order
    always_comb
    begin
        packed_cnt = 3'h0;
        for (int i = 0; i < `SFP_SLOTS; i++)
        begin
            packed_elem[i] = 24'h000000;
        end
        for (int i = 0; i < `SFP_SLOTS; i++)
        begin
            if (slot_code[i] != `SFP_CODE_NONE)
            begin
                packed_elem[packed_cnt[1:0]] = slot_element(slot_code[i],
                    opt_justify(IR_READING_I, OPT_RES_I),
                    opt_justify(RED_READING_I, OPT_RES_I),
                    opt_justify(IR_PILOT_READING_I, OPT_RES_I),
                    opt_justify(RED_PILOT_READING_I, OPT_RES_I),
                    CARDIO_READING_I);
                packed_cnt = packed_cnt + 3'h1;
            end
        end
    end

    // sample capture
    always_ff @(posedge CORE_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            for (int i = 0; i < `SFP_SLOTS; i++)
            begin
                sample_r[i] <= 24'h000000;
            end
            count_r <= 3'h0;
        end
        else if (SAMPLE_STROBE_I)
        begin
            for (int i = 0; i < `SFP_SLOTS; i++)
            begin
                sample_r[i] <= packed_elem[i];
            end
            count_r <= packed_cnt;
        end
    end

    // byte walk through the active elements
    always_ff @(posedge CORE_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            elem_sel_r <= 2'h0;
            byte_sel_r <= 2'h0;
            SAMPLE_POP_O <= 1'b0;
        end
        else
        begin
            SAMPLE_POP_O <= 1'b0;
            if (SAMPLE_STROBE_I)
            begin
                elem_sel_r <= 2'h0;
                byte_sel_r <= 2'h0;
            end
            else if (bus_rd && bus_addr == `SFP_ADDR_FIFO_DATA && count_r != 3'h0)
            begin
                if (byte_sel_r == `SFP_LAST_BYTE)
                begin
                    byte_sel_r <= 2'h0;
                    if ({1'b0, elem_sel_r} + 3'h1 == count_r)
                    begin
                        elem_sel_r <= 2'h0;
                        SAMPLE_POP_O <= 1'b1;
                    end
                    else
                    begin
                        elem_sel_r <= elem_sel_r + 2'h1;
                    end
                end
                else
                begin
                    byte_sel_r <= byte_sel_r + 2'h1;
                end
            end
        end
    end

    // current fifo byte, most significant first
    always_comb
    begin
        case (byte_sel_r)
            2'h0: fifo_byte = sample_r[elem_sel_r][23:16];
            2'h1: fifo_byte = sample_r[elem_sel_r][15:8];
            default: fifo_byte = sample_r[elem_sel_r][7:0];
        endcase
        if (count_r == 3'h0)
        begin
            fifo_byte = 8'h00;
        end
    end

    // register read mux
    always_comb
    begin
        case (bus_addr)
            `SFP_ADDR_FIFO_DATA: rdata = fifo_byte;
            `SFP_ADDR_SLOT_LOW: rdata = slot_config_low_pair_r;
            `SFP_ADDR_SLOT_HIGH: rdata = slot_config_high_pair_r;
            default: rdata = 8'h00;
        endcase
    end
endmodule

/* tb/sfp_packer_sva.sv */
// assertion checker for the sample fifo element packer ports
`timescale 1ns/100ps
module sfp_packer_sva (
    // clock and reset
    input wire logic CORE_CLK_I,
    input wire logic RST_I,
    // bus pins
    input wire logic SDA_O,
    // sample handling
    input wire logic SAMPLE_STROBE_I,
    input wire logic SAMPLE_POP_O,
    input wire logic [2:0] ELEMENT_COUNT_O,
    input wire logic [7:0] SLOT_CONFIG_LOW_O,
    input wire logic [7:0] SLOT_CONFIG_HIGH_O
);
    default clocking @(posedge CORE_CLK_I);
    endclocking
    default disable iff (RST_I);

    function automatic logic [2:0] n_active(input logic [7:0] lo, input logic [7:0] hi);
        return 3'(lo[3:0] != 4'h0) + 3'(lo[7:4] != 4'h0) + 3'(hi[3:0] != 4'h0)
            + 3'(hi[7:4] != 4'h0);
    endfunction

    property p_count_update;
        SAMPLE_STROBE_I |=> ELEMENT_COUNT_O ==
            n_active($past(SLOT_CONFIG_LOW_O), $past(SLOT_CONFIG_HIGH_O));
    endproperty
    a_count_update: assert property (p_count_update) else $error("count not updated");
    property p_count_hold;
        !SAMPLE_STROBE_I |=> $stable(ELEMENT_COUNT_O);
    endproperty
    a_count_hold: assert property (p_count_hold) else $error("count moved");
    property p_count_max;
        ELEMENT_COUNT_O <= 3'h4;
    endproperty
    a_count_max: assert property (p_count_max) else $error("count above four");
    property p_pop_pulse;
        SAMPLE_POP_O |=> !SAMPLE_POP_O [*8];
    endproperty
    a_pop_pulse: assert property (p_pop_pulse) else $error("pop too long");
    property p_no_pop_empty;
        ELEMENT_COUNT_O == 3'h0 |-> !SAMPLE_POP_O;
    endproperty
    a_no_pop_empty: assert property (p_no_pop_empty) else $error("pop when empty");
    property p_strobe_no_pop;
        SAMPLE_STROBE_I |=> !SAMPLE_POP_O;
    endproperty
    a_strobe_no_pop: assert property (p_strobe_no_pop) else $error("pop after strobe");
    property p_cfg_reset;
        $fell(RST_I) |-> SLOT_CONFIG_LOW_O == 8'h00 && SLOT_CONFIG_HIGH_O == 8'h00;
    endproperty
    a_cfg_reset: assert property (p_cfg_reset) else $error("slot regs not reset");
    property p_sda_low;
        SDA_O == 1'b0;
    endproperty
    a_sda_low: assert property (p_sda_low) else $error("sda output not low");
endmodule

bind sfp_packer sfp_packer_sva sva_u (
    .CORE_CLK_I(CORE_CLK_I),
    .RST_I(RST_I),
    .SDA_O(SDA_O),
    .SAMPLE_STROBE_I(SAMPLE_STROBE_I),
    .SAMPLE_POP_O(SAMPLE_POP_O),
    .ELEMENT_COUNT_O(ELEMENT_COUNT_O),
    .SLOT_CONFIG_LOW_O(SLOT_CONFIG_LOW_O),
    .SLOT_CONFIG_HIGH_O(SLOT_CONFIG_HIGH_O)
);

/* tb/sfp_host_model.sv */
// serial bus host model driving the packer's bus pins
`timescale 1ns/100ps
module sfp_host_model (
    // bus pins
    output logic scl_o,
    output logic sda_oe_o,
    input wire logic sda_i
);
    // clock stands high between frames, data released
    initial
    begin
        scl_o = 1'b1;
        sda_oe_o = 1'b0;
    end

    task automatic bstart();
        sda_oe_o = 1'b0;
        #50 scl_o = 1'b1;
        #50 sda_oe_o = 1'b1;
        #50 scl_o = 1'b0;
        #50;
    endtask

    task automatic bstop();
        sda_oe_o = 1'b1;
        #50 scl_o = 1'b1;
        #50 sda_oe_o = 1'b0;
        #100;
    endtask

    task automatic wbyte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--)
        begin
            sda_oe_o = ~b[i];
            #50 scl_o = 1'b1;
            #100 scl_o = 1'b0;
            #50;
        end
        sda_oe_o = 1'b0;
        #50 scl_o = 1'b1;
        #50 ack = ~sda_i;
        #50 scl_o = 1'b0;
        #50;
    endtask

    task automatic rbyte(input logic last, output logic [7:0] b);
        sda_oe_o = 1'b0;
        for (int i = 7; i >= 0; i--)
        begin
            #50 scl_o = 1'b1;
            #50 b[i] = sda_i;
            #50 scl_o = 1'b0;
            #50;
        end
        sda_oe_o = ~last;
        #50 scl_o = 1'b1;
        #100 scl_o = 1'b0;
        #50;
    endtask
endmodule

/* tb/sfp_packer_test.sv */
// self-checking bench for the sample fifo element packer
`timescale 1ns/100ps
`include "sfp_params.svh"
module sfp_packer_test;
    localparam logic [18:0] b_ir = 19'h5a5a5;
    localparam logic [18:0] b_red = 19'h3c3c3;
    localparam logic [18:0] b_irp = 19'h6b6b6;
    localparam logic [18:0] b_redp = 19'h1e1e1;
    localparam logic [17:0] b_ecg = 18'h2d2d2;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic strobe = 1'b0;
    logic [1:0] res = 2'h0;
    logic [18:0] ir = 19'h0, red = 19'h0, irp = 19'h0, redp = 19'h0;
    logic [17:0] ecg = 18'h0;
    logic scl, m_oe, sda_oe, pop;
    logic [2:0] cnt;
    logic [7:0] cfg_lo, cfg_hi;
    wire logic sda;
    int failures = 0, n_tests = 0, cyc = 0, n_pop = 0;

    // open-drain wire with pull-up
    assign sda = ~(sda_oe | m_oe);
    initial forever #12.5 clk = ~clk;

    sfp_packer dut_u (.CORE_CLK_I(clk), .RST_I(rst), .SCL_I(scl), .SDA_I(sda), .SDA_O(),
        .SDA_OE_O(sda_oe), .IR_READING_I(ir), .RED_READING_I(red), .IR_PILOT_READING_I(irp),
        .RED_PILOT_READING_I(redp), .CARDIO_READING_I(ecg), .OPT_RES_I(res),
        .SAMPLE_STROBE_I(strobe), .SAMPLE_POP_O(pop), .ELEMENT_COUNT_O(cnt),
        .SLOT_CONFIG_LOW_O(cfg_lo), .SLOT_CONFIG_HIGH_O(cfg_hi));
    sfp_host_model host_u (.scl_o(scl), .sda_oe_o(m_oe), .sda_i(sda));

    task automatic test_done();
        $display("checks %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    always @(negedge clk)
    begin
        if (pop)
            n_pop++;
        cyc++;
        if (cyc == 60000)
        begin
            failures++;
            test_done();
        end
    end

    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d0, input logic [7:0] d1);
        logic ack;
        host_u.bstart();
        host_u.wbyte({`SFP_SLAVE_ID, 1'b0}, ack);
        check("ack", {23'h0, ack}, 24'h1);
        host_u.wbyte(a, ack);
        host_u.wbyte(d0, ack);
        host_u.wbyte(d1, ack);
        host_u.bstop();
    endtask

    task automatic bus_read(input logic [7:0] a, input int n, output logic [7:0] q[$]);
        logic ack;
        logic [7:0] b;
        q = {};
        host_u.bstart();
        host_u.wbyte({`SFP_SLAVE_ID, 1'b0}, ack);
        host_u.wbyte(a, ack);
        host_u.bstart();
        host_u.wbyte({`SFP_SLAVE_ID, 1'b1}, ack);
        for (int i = 0; i < n; i++)
        begin
            host_u.rbyte(i == n - 1, b);
            q.push_back(b);
        end
        host_u.bstop();
    endtask

    function automatic logic [23:0] elem(input logic [3:0] c, input logic [1:0] r);
        logic [18:0] v;
        case (c)
            `SFP_CODE_IR: v = b_ir;
            `SFP_CODE_RED: v = b_red;
            `SFP_CODE_IR_PILOT: v = b_irp;
            `SFP_CODE_RED_PILOT: v = b_redp;
            `SFP_CODE_CARDIO: return {6'h00, b_ecg};
            default: return 24'h0;
        endcase
        return {5'h00, (v >> (3 - r)) << (3 - r)};
    endfunction

    task automatic t_regs();
        logic [7:0] q[$];
        logic ack;
        check("cfg_lo", {16'h0, cfg_lo}, 24'h0);
        check("cfg_hi", {16'h0, cfg_hi}, 24'h0);
        bus_read(`SFP_ADDR_SLOT_LOW, 3, q);
        check("rd_lo", {16'h0, q[0]}, 24'h0);
        check("rd_hi", {16'h0, q[1]}, 24'h0);
        check("rd_unmapped", {16'h0, q[2]}, 24'h0);
        reg_write(`SFP_ADDR_SLOT_LOW, 8'ha5, 8'h3c);
        bus_read(`SFP_ADDR_SLOT_LOW, 3, q);
        check("rd_lo", {16'h0, q[0]}, 24'ha5);
        check("rd_hi", {16'h0, q[1]}, 24'h3c);
        check("rd_unmapped", {16'h0, q[2]}, 24'h0);
        check("cfg_lo", {16'h0, cfg_lo}, 24'ha5);
        check("cfg_hi", {16'h0, cfg_hi}, 24'h3c);
        host_u.bstart();
        host_u.wbyte(8'h56, ack);
        host_u.bstop();
        check("wrong_id_ack", {23'h0, ack}, 24'h0);
    endtask

    task automatic t_sample(input logic [7:0] lo, input logic [7:0] hi, input logic [1:0] r);
        logic [7:0] q[$];
        logic [3:0] codes[$];
        logic [15:0] cfg;
        logic [23:0] e;
        int n, p;
        cfg = {hi, lo};
        codes = {};
        for (int i = 0; i < 4; i++)
            if (cfg[4 * i +: 4] != 4'h0)
                codes.push_back(cfg[4 * i +: 4]);
        n = codes.size();
        reg_write(`SFP_ADDR_SLOT_LOW, lo, hi);
        @(negedge clk);
        res = r;
        ir = b_ir >> (3 - r);
        red = b_red >> (3 - r);
        irp = b_irp >> (3 - r);
        redp = b_redp >> (3 - r);
        ecg = b_ecg;
        strobe = 1'b1;
        @(negedge clk);
        strobe = 1'b0;
        @(negedge clk);
        check("count", {21'h0, cnt}, 24'(n));
        p = n_pop;
        bus_read(`SFP_ADDR_FIFO_DATA, (n == 0) ? 1 : 3 * n + 3, q);
        if (n == 0)
            check("empty_byte", {16'h0, q[0]}, 24'h0);
        for (int i = 0; n > 0 && i < q.size(); i++)
        begin
            e = elem(codes[(i / 3) % n], r);
            check("byte", {16'h0, q[i]}, {16'h0, e[23 - 8 * (i % 3) -: 8]});
        end
        check("pops", 24'(n_pop - p), (n == 1) ? 24'h2 : 24'(n != 0));
    endtask

    initial
    begin
        repeat (16) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        t_regs();
        // slots filled from slot zero: optical then cardio, pilots, cardio alone, four optical, none
        t_sample(8'h21, 8'h09, 2'h3);
        t_sample(8'h65, 8'h00, 2'h0);
        t_sample(8'h09, 8'h00, 2'h2);
        t_sample(8'h21, 8'h65, 2'h1);
        t_sample(8'h00, 8'h00, 2'h3);
        test_done();
    end
endmodule
